// ### post_code_map.svh
// constants for the progress-code display decoder
`ifndef POST_CODE_MAP_SVH
`define POST_CODE_MAP_SVH
`define PORT_LOW_PRIMARY 16'h0080
`define PORT_HIGH_PRIMARY 16'h0084
`define PORT_LOW_ALT 16'h0090
`define PORT_HIGH_ALT 16'h0094
`define PCI_CMD_IO_WRITE 4'h3
`define LPC_START 4'h0
`define LPC_CYC_IO_WRITE 4'h2
`define SEG_BLANK 7'h00
`endif

// ### post_code_pkg.sv
// types for the progress-code display decoder
package post_code_pkg;
   typedef struct packed {
      logic frameN;
      logic [31:0] ad;
      logic [3:0] cbeN;
      logic irdyN;
      logic trdyN;
   } pci_pins_t;
   typedef struct packed {
      logic frameN;
      logic [3:0] lad;
   } lpc_pins_t;
   typedef struct packed {
      logic [6:0] seg;
      logic dp;
   } digit_t;
   typedef enum {LPC_IDLE, LPC_CYC, LPC_A3, LPC_A2, LPC_A1, LPC_A0, LPC_D0, LPC_D1} lpc_state_t;
endpackage : post_code_pkg

// ### post_code_display_decoder.sv
// progress-code capture and seven-segment display
//
// Operation
// RL1 - catch host I/O writes to chosen ports, show them on four digits
// RL2 - keep the last captured code shown until a newer write arrives
// RL3 - digit one dot shows system reset, digit two dot shows PCI frame
// RL4 - source switch on takes PCI codes, off takes LPC codes
// RL5 - address switch on decodes 80h/84h, off decodes 90h/94h
// RL6 - host firmware writes progress codes as I/O writes, normally port 80h
// RL7 - each byte shown as two hex digits; low port first pair, high second
`include "post_code_map.svh"
module post_code_display_decoder
   import post_code_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire pci_pins_t pciPins,
   input wire lpc_pins_t lpcPins,
   input wire logic postSourceSwitch,
   input wire logic postAddrSwitch,
   input wire logic systemResetInN,
   output digit_t firstCodeDigit,
   output digit_t secondCodeDigit,
   output digit_t thirdCodeDigit,
   output digit_t lastCodeDigit
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   // sampled as ordinary inputs; a code needs the bus to dwell long enough
   // per phase, so this suits slow or stretched buses only
   localparam int SW = $bits(pci_pins_t) + $bits(lpc_pins_t) + 3;
   logic [SW-1:0] meta_q, sync_q, meta_d, sync_d;
   pci_pins_t pci;
   lpc_pins_t lpc;
   logic srcPci, addrPrimary, rstInN;
   always_comb begin
      meta_d = {pciPins, lpcPins, postSourceSwitch, postAddrSwitch, systemResetInN};
      sync_d = meta_q;
      {pci, lpc, srcPci, addrPrimary, rstInN} = sync_q;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         // restart at the idle pin levels (lines pulled up, switches at default)
         // so no false frame edge or lit reset dot follows srst
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // returns 2'b01 for the low port, 2'b10 for the high port
   function automatic logic [1:0] portHit(input logic [15:0] a, input logic prim);
      logic [15:0] lo, hi;
      lo = prim ? `PORT_LOW_PRIMARY : `PORT_LOW_ALT;
      hi = prim ? `PORT_HIGH_PRIMARY : `PORT_HIGH_ALT;
      portHit = {a == hi, a == lo};
   endfunction : portHit

   // ---------------------------------------------------------------
   // PCI snoop
   // ---------------------------------------------------------------
   logic pciFramePrev_q, pciFramePrev_d;
   logic [1:0] pciHit_q, pciHit_d;
   logic [1:0] pciWr;
   logic [7:0] pciByte;
   always_comb begin
      pciFramePrev_d = pci.frameN;
      pciHit_d = pciHit_q;
      pciWr = 2'b00;
      pciByte = pci.ad[7:0];
      if (pciFramePrev_q && !pci.frameN) begin
         // i/o space is 32 bits wide; a nonzero upper half is an alias, not our port
         pciHit_d = (pci.cbeN == `PCI_CMD_IO_WRITE && pci.ad[31:16] == 16'h0000)
            ? portHit(pci.ad[15:0], addrPrimary) : 2'b00; // RL5
      end
      if (!pci.irdyN && !pci.trdyN && pciHit_q != 2'b00) begin
         // both ports sit in byte lane 0, so the code is always ad[7:0]
         pciWr = pci.cbeN[0] ? 2'b00 : pciHit_q; // RL1
         // one data phase per address is taken; bursts are not decoded
         pciHit_d = 2'b00;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pciFramePrev_q <= 1'b1;
         pciHit_q <= 2'b00;
      end else begin
         pciFramePrev_q <= pciFramePrev_d;
         pciHit_q <= pciHit_d;
      end
   end

   // ---------------------------------------------------------------
   // LPC snoop
   // ---------------------------------------------------------------
   lpc_state_t lpcState_q, lpcState_d;
   logic [15:0] lpcAddr_q, lpcAddr_d;
   logic [3:0] lpcLow_q, lpcLow_d;
   logic [1:0] lpcWr;
   logic [7:0] lpcByte;
   always_comb begin
      lpcState_d = lpcState_q;
      lpcAddr_d = lpcAddr_q;
      lpcLow_d = lpcLow_q;
      lpcWr = 2'b00;
      lpcByte = {lpc.lad, lpcLow_q};
      if (!lpc.frameN) begin
         // frame low restarts any cycle, also an abort
         lpcState_d = (lpc.lad == `LPC_START) ? LPC_CYC : LPC_IDLE;
      end else begin
         case (lpcState_q)
            LPC_IDLE: lpcState_d = LPC_IDLE;
            LPC_CYC: lpcState_d = (lpc.lad[3:1] == `LPC_CYC_IO_WRITE >> 1 && !lpc.lad[0])
                                  ? LPC_A3 : LPC_IDLE;
            LPC_A3: begin
               lpcAddr_d[15:12] = lpc.lad;
               lpcState_d = LPC_A2;
            end
            LPC_A2: begin
               lpcAddr_d[11:8] = lpc.lad;
               lpcState_d = LPC_A1;
            end
            LPC_A1: begin
               lpcAddr_d[7:4] = lpc.lad;
               lpcState_d = LPC_A0;
            end
            LPC_A0: begin
               lpcAddr_d[3:0] = lpc.lad;
               lpcState_d = LPC_D0;
            end
            LPC_D0: begin
               lpcLow_d = lpc.lad;
               lpcState_d = LPC_D1;
            end
            LPC_D1: begin
               // high nibble is still on lad, so the byte is judged in this cycle
               lpcWr = portHit(lpcAddr_q, addrPrimary); // RL5
               lpcState_d = LPC_IDLE;
            end
            default: lpcState_d = LPC_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lpcState_q <= LPC_IDLE;
         lpcAddr_q <= 16'h0000;
         lpcLow_q <= 4'h0;
      end else begin
         lpcState_q <= lpcState_d;
         lpcAddr_q <= lpcAddr_d;
         lpcLow_q <= lpcLow_d;
      end
   end

   // ---------------------------------------------------------------
   // captured codes and display
   // ---------------------------------------------------------------
   function automatic logic [6:0] hexSeg(input logic [3:0] n);
      case (n)
         4'h0: hexSeg = 7'h3f;
         4'h1: hexSeg = 7'h06;
         4'h2: hexSeg = 7'h5b;
         4'h3: hexSeg = 7'h4f;
         4'h4: hexSeg = 7'h66;
         4'h5: hexSeg = 7'h6d;
         4'h6: hexSeg = 7'h7d;
         4'h7: hexSeg = 7'h07;
         4'h8: hexSeg = 7'h7f;
         4'h9: hexSeg = 7'h6f;
         4'ha: hexSeg = 7'h77;
         4'hb: hexSeg = 7'h7c;
         4'hc: hexSeg = 7'h39;
         4'hd: hexSeg = 7'h5e;
         4'he: hexSeg = 7'h79;
         4'hf: hexSeg = 7'h71;
         default: hexSeg = `SEG_BLANK;
      endcase
   endfunction : hexSeg

   logic [7:0] codeLow_q, codeLow_d, codeHigh_q, codeHigh_d;
   logic [1:0] wr;
   logic [7:0] wrByte;
   digit_t d0_d, d1_d, d2_d, d3_d;
   always_comb begin
      // both buses are snooped all the time; only the chosen one may write
      wr = srcPci ? pciWr : lpcWr; // RL4
      wrByte = srcPci ? pciByte : lpcByte; // RL4
      codeLow_d = wr[0] ? wrByte : codeLow_q; // RL1 RL2
      codeHigh_d = wr[1] ? wrByte : codeHigh_q; // RL1 RL2
      d0_d = '{seg: hexSeg(codeLow_q[7:4]), dp: !rstInN}; // RL7 RL3
      d1_d = '{seg: hexSeg(codeLow_q[3:0]), dp: !pci.frameN}; // RL7 RL3
      // the upper pair has no indicator of its own, so its dots stay dark
      d2_d = '{seg: hexSeg(codeHigh_q[7:4]), dp: 1'b0}; // RL7
      d3_d = '{seg: hexSeg(codeHigh_q[3:0]), dp: 1'b0}; // RL7
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         codeLow_q <= 8'h00;
         codeHigh_q <= 8'h00;
         firstCodeDigit <= '0;
         secondCodeDigit <= '0;
         thirdCodeDigit <= '0;
         lastCodeDigit <= '0;
      end else begin
         codeLow_q <= codeLow_d;
         codeHigh_q <= codeHigh_d;
         // digits come straight from flops so the segment lines never glitch
         firstCodeDigit <= d0_d;
         secondCodeDigit <= d1_d;
         thirdCodeDigit <= d2_d;
         lastCodeDigit <= d3_d;
      end
   end
endmodule : post_code_display_decoder

// ### post_code_checker.sv
// port assertions for the progress-code decoder
module post_code_checker
   import post_code_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire pci_pins_t pciPins,
   input wire lpc_pins_t lpcPins,
   input wire logic postSourceSwitch,
   input wire logic systemResetInN,
   input wire digit_t firstCodeDigit,
   input wire digit_t secondCodeDigit,
   input wire digit_t thirdCodeDigit,
   input wire digit_t lastCodeDigit
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   chk_reset_dot: assert property ((!srst && !systemResetInN) [*3] |=> firstCodeDigit.dp)
      else $error("reset dot dark");
   chk_frame_dot: assert property ((!srst && !pciPins.frameN) [*3] |=> secondCodeDigit.dp)
      else $error("frame dot dark");
   chk_digits_lit: assert property ((!srst) [*3] |->
      firstCodeDigit.seg != 7'h00 && lastCodeDigit.seg != 7'h00) else $error("digit blank");
   chk_code_holds: assert property ((!srst && postSourceSwitch && pciPins.frameN) [*8] |->
      $stable(firstCodeDigit.seg) && $stable(thirdCodeDigit.seg)) else $error("code moved");
   // with the lpc source chosen, a pci write while the lpc side idles must leave the code alone
   chk_pci_ignored: assert property ((!postSourceSwitch && lpcPins == 5'h1f) [*8] |->
      $stable(firstCodeDigit.seg) && $stable(lastCodeDigit.seg)) else $error("pci taken");
   chk_upper_dots: assert property (!thirdCodeDigit.dp && !lastCodeDigit.dp)
      else $error("upper dot lit");
   cover property (postSourceSwitch ##1 $changed(firstCodeDigit.seg));
   cover property (!postSourceSwitch ##1 $changed(firstCodeDigit.seg));
   cover property ($rose(secondCodeDigit.dp));
endmodule : post_code_checker
bind post_code_display_decoder post_code_checker u_post_code_checker (.sys_clk(sys_clk),
   .srst(srst), .pciPins(pciPins), .lpcPins(lpcPins), .postSourceSwitch(postSourceSwitch),
   .systemResetInN(systemResetInN), .firstCodeDigit(firstCodeDigit),
   .secondCodeDigit(secondCodeDigit), .thirdCodeDigit(thirdCodeDigit),
   .lastCodeDigit(lastCodeDigit));

// ### post_host.sv
// host firmware model writing progress codes over pci or lpc
`include "post_code_map.svh"
module post_host
   import post_code_pkg::*;
(
   input wire logic sys_clk,
   output pci_pins_t pciPins,
   output lpc_pins_t lpcPins
);
   timeunit 1ns;
   timeprecision 1ns;
   // released lines sit at the pull-up level, never at the last value
   localparam pci_pins_t pciIdle = '{1'b1, 32'hffffffff, 4'hf, 1'b1, 1'b1};
   initial begin
      pciPins = pciIdle;
      lpcPins = '{1'b1, 4'hf};
   end
   task automatic pci_wr(input logic [15:0] a, input logic [7:0] d,
      input logic [3:0] c = `PCI_CMD_IO_WRITE, input logic [3:0] be = 4'he);
      @(posedge sys_clk) pciPins <= '{1'b0, {16'h0000, a}, c, 1'b1, 1'b1};
      repeat (3) @(posedge sys_clk);
      pciPins <= '{1'b1, {24'h000000, d}, be, 1'b0, 1'b0};
      repeat (3) @(posedge sys_clk);
      pciPins <= pciIdle;
   endtask : pci_wr
   task automatic lpc_wr(input logic [15:0] a, input logic [7:0] d);
      logic [31:0] n;
      n = {`LPC_START, `LPC_CYC_IO_WRITE, a, d[3:0], d[7:4]};
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk) lpcPins <= '{i != 0, n[31 - 4 * i -: 4]};
      end
      @(posedge sys_clk) lpcPins <= '{1'b1, 4'hf};
   endtask : lpc_wr
endmodule : post_host

// ### post_code_display_decoder_bench.sv
// self-checking bench for the progress-code decoder
module post_code_display_decoder_bench
   import post_code_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] hexFont [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d,
      7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic postSourceSwitch = 1'b1;
   logic postAddrSwitch = 1'b1;
   logic systemResetInN = 1'b1;
   pci_pins_t pciPins;
   lpc_pins_t lpcPins;
   digit_t dig [4];
   int nMismatch = 0;
   int nCompared = 0;
   post_code_display_decoder u_post_code_display_decoder (.sys_clk(sys_clk), .srst(srst),
      .pciPins(pciPins), .lpcPins(lpcPins), .postSourceSwitch(postSourceSwitch),
      .postAddrSwitch(postAddrSwitch), .systemResetInN(systemResetInN),
      .firstCodeDigit(dig[0]), .secondCodeDigit(dig[1]), .thirdCodeDigit(dig[2]),
      .lastCodeDigit(dig[3]));
   post_host u_post_host (.sys_clk(sys_clk), .pciPins(pciPins), .lpcPins(lpcPins));
   initial forever #25 sys_clk = ~sys_clk;
   task automatic check(input int idx, input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nMismatch++;
         $display("mismatch digit%0d expected %h seen %h", idx, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", nCompared, nMismatch);
      if (nMismatch == 0 && nCompared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   // codes land four edges after the data, so eight leaves margin
   task automatic expect_code(input logic [15:0] code);
      repeat (8) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 4; i++) begin
         // dots are dark here: reset and frame both idle between scenarios
         check(i, dig[i], {hexFont[code[15 - 4 * i -: 4]], 1'b0});
      end
   endtask : expect_code
   task automatic pci_ports();
      u_post_host.pci_wr(16'h0080, 8'ha5);
      u_post_host.pci_wr(16'h0084, 8'h3c);
      expect_code(16'ha53c);
      u_post_host.pci_wr(16'h0080, 8'h11, 4'h2);
      u_post_host.pci_wr(16'h0080, 8'h22, 4'h3, 4'hf);
      u_post_host.lpc_wr(16'h0080, 8'h11);
      expect_code(16'ha53c);
   endtask : pci_ports
   task automatic alt_ports();
      @(posedge sys_clk) postAddrSwitch <= 1'b0;
      u_post_host.pci_wr(16'h0094, 8'hf0);
      u_post_host.pci_wr(16'h0084, 8'h99);
      expect_code(16'ha5f0);
   endtask : alt_ports
   task automatic lpc_source();
      @(posedge sys_clk) postSourceSwitch <= 1'b0;
      u_post_host.pci_wr(16'h0090, 8'h44);
      u_post_host.lpc_wr(16'h0090, 8'h6b);
      u_post_host.lpc_wr(16'h0080, 8'h77);
      expect_code(16'h6bf0);
   endtask : lpc_source
   task automatic reset_dot();
      @(posedge sys_clk) systemResetInN <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      check(0, {7'h00, dig[0].dp}, 8'h01);
      @(posedge sys_clk) systemResetInN <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      check(0, {7'h00, dig[0].dp}, 8'h00);
   endtask : reset_dot
   // the frame dot is sampled after frame has risen again at the pins; the sync and digit flops still hold it lit
   task automatic frame_dot();
      fork
         u_post_host.pci_wr(16'h0080, 8'h5a, 4'h2);
         begin
            repeat (5) @(posedge sys_clk);
            #1;
            check(1, {7'h00, dig[1].dp}, 8'h01);
         end
      join
      expect_code(16'h6bf0);
   endtask : frame_dot
   task automatic mid_reset();
      @(posedge sys_clk) srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      expect_code(16'h0000);
   endtask : mid_reset
   initial begin
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      expect_code(16'h0000);
      pci_ports();
      alt_ports();
      lpc_source();
      reset_dot();
      frame_dot();
      mid_reset();
      report_and_stop();
   end
   // the whole sequence needs about 160 cycles
   initial begin
      repeat (1500) @(posedge sys_clk);
      nMismatch++;
      report_and_stop();
   end
endmodule : post_code_display_decoder_bench
